//--- tsa_core.sv
// tag state machine and slotted anticollision logic
// Summary of operation
// - weak field keeps tag powered off and silent
// - field good: enter ready, reset logic, load random handle
// - ready state ignores all but inventory-open
// - inventory-open in ready moves to inventory
// - inventory answers anticollision commands and stays there
// - pick-tag with own handle selects; other handle stays inventory
// - selected serves access commands, ignores anticollision
// - pick-tag with foreign handle in selected deselects
// - retire in selected deactivates
// - deselected returns to selected only on matching pick-tag
// - deactivated ignores everything until field loss
// - tag holds an 8-bit handle, one of 256
// - new random handle at ready and each inventory-open received in inventory
// - inventory-open in inventory answers handle at once, no slot; in ready it gives no answer
// - slot nibble is handle bits 0 to 3
// - slot-zero-call draws new nibble, answers only if zero
// - slot-probe answers handle only when nibble equals slot
// - slot-zero or slot-probe answer given once per anticollision round
// - bad checksum or unknown command dropped silently
// - fixed handle option replaces random handle generation
`timescale 1ns/1ps
`default_nettype none
module tsa_core (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          field_ok,
  input  wire logic                          fixed_handle_en,
  input  wire logic [tsa_pkg::HANDLE_W-1:0]  fixed_handle,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_crc_ok,
  input  wire logic [tsa_pkg::CMD_W-1:0]     cmd_code,
  input  wire logic [tsa_pkg::HANDLE_W-1:0]  cmd_param,
  output var  tsa_pkg::tsa_state_t           tag_state,
  output logic [tsa_pkg::HANDLE_W-1:0]       tag_handle,
  output logic                               ans_valid,
  output logic [tsa_pkg::HANDLE_W-1:0]       ans_handle,
  output logic                               serve_valid,
  output logic [tsa_pkg::CMD_W-1:0]          serve_cmd
);
  import tsa_pkg::*;

  // synchronisers for pins
  logic                field_meta_reg;
  logic                field_s_reg;
  logic                fixed_en_meta_reg;
  logic                fixed_en_s_reg;
  logic [HANDLE_W-1:0] fixed_meta_reg;
  logic [HANDLE_W-1:0] fixed_s_reg;
  tsa_state_t          state_reg;
  tsa_state_t          state_next;
  logic [HANDLE_W-1:0] handle_reg;
  logic [HANDLE_W-1:0] handle_next;
  logic                answered_reg;
  logic                answered_next;
  logic                ans_valid_reg;
  logic [HANDLE_W-1:0] ans_handle_reg;
  logic                serve_valid_reg;
  logic [CMD_W-1:0]    serve_cmd_reg;
  logic [RND_W-1:0]    rnd;
  logic [HANDLE_W-1:0] new_handle;
  logic [NIB_W-1:0]    new_nib;
  logic                cmd_known;
  logic                cmd_ok;
  logic                powerup;
  logic                in_inv;
  logic                is_inv_open;
  logic                is_zero_call;
  logic                is_probe;
  logic                is_pick;
  logic                is_retire;
  logic                is_access;
  logic                handle_hit;
  logic                slot_hit;
  logic                zero_ans;
  logic                probe_ans;

  // only the second stage is read anywhere
  always_ff @(posedge mclk) begin
    if (rst) begin
      field_meta_reg <= 1'b0;
      field_s_reg    <= 1'b0;
    end else begin
      field_meta_reg <= field_ok;
      field_s_reg    <= field_meta_reg;
    end
  end

  // option straps are static but still arrive from a pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      fixed_en_meta_reg <= 1'b0;
      fixed_en_s_reg    <= 1'b0;
      fixed_meta_reg    <= HANDLE_RST;
      fixed_s_reg       <= HANDLE_RST;
    end else begin
      fixed_en_meta_reg <= fixed_handle_en;
      fixed_en_s_reg    <= fixed_en_meta_reg;
      fixed_meta_reg    <= fixed_handle;
      fixed_s_reg       <= fixed_meta_reg;
    end
  end

  // not cleared by field loss, so tags powered later diverge
  tsa_lfsr #(
    .W    (RND_W),
    .SEED (RND_SEED)
  ) u_rnd (
    .mclk (mclk),
    .rst  (rst),
    .rnd  (rnd)
  );

  always_comb begin
    case (cmd_code)
      CMD_INV_OPEN, CMD_SLOT_ZERO, CMD_SLOT_PROBE,
      CMD_PICK_TAG, CMD_BLOCK_FETCH, CMD_BLOCK_STORE,
      CMD_ANTI_CLONE, CMD_UID_FETCH,
      CMD_RETIRE: cmd_known = 1'b1;
      default:    cmd_known = 1'b0;
    endcase
  end

  // a bad frame never reaches the state logic
  assign cmd_ok = cmd_valid && cmd_crc_ok && cmd_known
               && field_s_reg;

  assign powerup      = (state_reg == ST_OFF) && field_s_reg;
  assign in_inv       = (state_reg == ST_INVENTORY);
  assign is_inv_open  = cmd_ok && (cmd_code == CMD_INV_OPEN);
  assign is_zero_call = cmd_ok && (cmd_code == CMD_SLOT_ZERO);
  assign is_probe     = cmd_ok && (cmd_code == CMD_SLOT_PROBE);
  assign is_pick      = cmd_ok && (cmd_code == CMD_PICK_TAG);
  assign is_retire    = cmd_ok && (cmd_code == CMD_RETIRE);
  // access codes are kept contiguous so one range test covers them
  assign is_access    = cmd_ok && (cmd_code >= CMD_BLOCK_FETCH)
                     && (cmd_code <= CMD_UID_FETCH);
  assign handle_hit   = (cmd_param == handle_reg);

  // fixed handle freezes both handle and nibble
  assign new_handle = fixed_en_s_reg ? fixed_s_reg : rnd[HANDLE_W-1:0];
  assign new_nib    = fixed_en_s_reg ? handle_reg[NIB_W-1:0]
                    : rnd[RND_NIB_LSB +: NIB_W];

  assign slot_hit  = (handle_reg[NIB_W-1:0] == cmd_param[NIB_W-1:0]);
  assign zero_ans  = in_inv && is_zero_call && !answered_reg
                  && (new_nib == SLOT_ZERO);
  assign probe_ans = in_inv && is_probe && !answered_reg
                  && slot_hit;

  always_comb begin
    state_next = state_reg;
    if (!field_s_reg) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF:         state_next = ST_READY;
        ST_READY: begin
          if (is_inv_open) begin
            state_next = ST_INVENTORY;
          end
        end
        ST_INVENTORY: begin
          if (is_pick && handle_hit) begin
            state_next = ST_SELECTED;
          end
        end
        ST_SELECTED: begin
          if (is_pick && !handle_hit) begin
            state_next = ST_DESELECTED;
          end else if (is_retire) begin
            state_next = ST_DEACTIVATED;
          end
        end
        ST_DESELECTED: begin
          if (is_pick && handle_hit) begin
            state_next = ST_SELECTED;
          end
        end
        ST_DEACTIVATED: state_next = ST_DEACTIVATED;
        default:        state_next = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    handle_next = handle_reg;
    if (powerup) begin
      handle_next = new_handle;
    end else if (in_inv && is_inv_open) begin
      handle_next = new_handle;
    end else if (in_inv && is_zero_call) begin
      handle_next = {handle_reg[HANDLE_W-1:NIB_W],
                     new_nib};
    end
  end

  // one 8-bit handle, 256 possible values
  always_ff @(posedge mclk) begin
    if (rst) begin
      handle_reg <= HANDLE_RST;
    end else begin
      handle_reg <= handle_next;
    end
  end

  // a new round opens at inventory-open or slot-zero-call;
  // an answer in the same cycle wins over the clear
  always_comb begin
    answered_next = answered_reg;
    if (zero_ans || probe_ans) begin
      answered_next = 1'b1;
    end else if (powerup
              || (in_inv && (is_inv_open || is_zero_call))) begin
      answered_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      answered_reg <= 1'b0;
    end else begin
      answered_reg <= answered_next;
    end
  end

  // answer goes out one cycle after the command is taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      ans_valid_reg  <= 1'b0;
      ans_handle_reg <= HANDLE_RST;
    end else begin
      ans_valid_reg <= 1'b0;
      if (in_inv && is_inv_open) begin
        ans_valid_reg  <= 1'b1;
        ans_handle_reg <= new_handle;
      end else if (zero_ans) begin
        ans_valid_reg  <= 1'b1;
        ans_handle_reg <= handle_next;
      end else if (probe_ans) begin
        ans_valid_reg  <= 1'b1;
        ans_handle_reg <= handle_reg;
      end
    end
  end

  // access commands are handed to the memory side only
  always_ff @(posedge mclk) begin
    if (rst) begin
      serve_valid_reg <= 1'b0;
      serve_cmd_reg   <= CMD_INV_OPEN;
    end else begin
      serve_valid_reg <= 1'b0;
      if ((state_reg == ST_SELECTED) && is_access) begin
        serve_valid_reg <= 1'b1;
        serve_cmd_reg   <= cmd_code;
      end
    end
  end

  assign tag_state   = state_reg;
  assign tag_handle  = handle_reg;
  assign ans_valid   = ans_valid_reg;
  assign ans_handle  = ans_handle_reg;
  assign serve_valid = serve_valid_reg;
  assign serve_cmd   = serve_cmd_reg;

  a_off_silent: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_OFF) |=> !ans_valid_reg && !serve_valid_reg
  ) else $error("answer while powered off");
  a_powerup_ready: assert property (
    @(posedge mclk) disable iff (rst)
    powerup |=> (state_reg == ST_READY) && !answered_reg
  ) else $error("power-up did not reach ready");
  a_ready_ignore: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_READY) && field_s_reg && !is_inv_open
    |=> (state_reg == ST_READY) && !ans_valid_reg
  ) else $error("ready state reacted to a command");
  a_ready_to_inv: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_READY) && field_s_reg && is_inv_open
    |=> (state_reg == ST_INVENTORY)
  ) else $error("inventory-open did not enter inventory");
  a_inv_open_ans: assert property (
    @(posedge mclk) disable iff (rst)
    in_inv && field_s_reg && is_inv_open
    |=> ans_valid_reg && (ans_handle_reg == handle_reg)
        && (state_reg == ST_INVENTORY)
  ) else $error("inventory-open answer missing");
  a_pick_select: assert property (
    @(posedge mclk) disable iff (rst)
    in_inv && field_s_reg && is_pick
    |=> (state_reg == ($past(handle_hit) ? ST_SELECTED
                                         : ST_INVENTORY))
  ) else $error("pick-tag in inventory misrouted");
  a_sel_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_SELECTED) ##1 (state_reg == ST_SELECTED)
    |=> !ans_valid_reg
  ) else $error("selected tag answered anticollision");
  a_sel_deselect: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_SELECTED) && field_s_reg && is_pick
    && !handle_hit |=> (state_reg == ST_DESELECTED)
  ) else $error("foreign pick-tag did not deselect");
  a_retire_deact: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_SELECTED) && field_s_reg && is_retire
    |=> (state_reg == ST_DEACTIVATED)
  ) else $error("retire did not deactivate");
  a_desel_hold: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_DESELECTED) && field_s_reg
    && !(is_pick && handle_hit)
    |=> (state_reg == ST_DESELECTED) && !ans_valid_reg
  ) else $error("deselected tag left without match");
  a_deact_stay: assert property (
    @(posedge mclk) disable iff (rst)
    (state_reg == ST_DEACTIVATED) && field_s_reg
    |=> (state_reg == ST_DEACTIVATED) && !ans_valid_reg
        && !serve_valid_reg
  ) else $error("deactivated tag reacted");
  a_probe_match: assert property (
    @(posedge mclk) disable iff (rst)
    in_inv && is_probe && !answered_reg
    |=> (ans_valid_reg == $past(slot_hit))
  ) else $error("slot-probe answer wrong");
  a_zero_nibble: assert property (
    @(posedge mclk) disable iff (rst)
    zero_ans |=> ans_valid_reg
      && (ans_handle_reg[NIB_W-1:0] == SLOT_ZERO)
      && (handle_reg == ans_handle_reg)
  ) else $error("slot-zero answer wrong");
  a_answer_once: assert property (
    @(posedge mclk) disable iff (rst)
    answered_reg && in_inv && is_probe |=> !ans_valid_reg
  ) else $error("second answer in one round");
  a_fixed_handle: assert property (
    @(posedge mclk) disable iff (rst)
    powerup && fixed_en_s_reg
    |=> (handle_reg == $past(fixed_s_reg))
  ) else $error("fixed handle not used");
  a_field_loss: assert property (
    @(posedge mclk) disable iff (rst)
    !field_s_reg |=> (state_reg == ST_OFF)
  ) else $error("field loss did not power off");

endmodule : tsa_core
`default_nettype wire

//--- tsa_pkg.sv
// shared constants and types for the tag state and anticollision block
package tsa_pkg;

  localparam int HANDLE_W    = 8;
  localparam int NIB_W       = 4;
  localparam int CMD_W       = 4;
  localparam int RND_W       = 16;
  localparam int RND_NIB_LSB = 8;

  localparam logic [RND_W-1:0]    RND_SEED   = 16'hace1;
  localparam logic [HANDLE_W-1:0] HANDLE_RST = 8'h00;
  localparam logic [NIB_W-1:0]    SLOT_ZERO  = 4'h0;

  typedef enum logic [2:0] {
    ST_OFF         = 3'b000,
    ST_READY       = 3'b001,
    ST_INVENTORY   = 3'b010,
    ST_SELECTED    = 3'b011,
    ST_DESELECTED  = 3'b100,
    ST_DEACTIVATED = 3'b101
  } tsa_state_t;

  // command codes as delivered by the frame decoder
  localparam logic [CMD_W-1:0] CMD_INV_OPEN    = 4'h0;
  localparam logic [CMD_W-1:0] CMD_SLOT_ZERO   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_SLOT_PROBE  = 4'h2;
  localparam logic [CMD_W-1:0] CMD_PICK_TAG    = 4'h3;
  localparam logic [CMD_W-1:0] CMD_BLOCK_FETCH = 4'h4;
  localparam logic [CMD_W-1:0] CMD_BLOCK_STORE = 4'h5;
  localparam logic [CMD_W-1:0] CMD_ANTI_CLONE  = 4'h6;
  localparam logic [CMD_W-1:0] CMD_UID_FETCH   = 4'h7;
  localparam logic [CMD_W-1:0] CMD_RETIRE      = 4'h8;

endpackage : tsa_pkg

//--- tsa_lfsr.sv
// free-running pseudo-random source for handle and slot draws
`timescale 1ns/1ps
`default_nettype none
module tsa_lfsr #(
  parameter int                  W    = 16,
  parameter logic [W-1:0]        SEED = '1
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  output logic [W-1:0]           rnd
);

  logic [W-1:0] lfsr_reg;
  logic         fb;

  // taps 16,14,13,11: maximal length, never reaches all zeros
  assign fb = lfsr_reg[W-1] ^ lfsr_reg[W-3] ^ lfsr_reg[W-4]
            ^ lfsr_reg[W-6];

  always_ff @(posedge mclk) begin
    if (rst) begin
      lfsr_reg <= SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[W-2:0], fb};
    end
  end

  assign rnd = lfsr_reg;

endmodule : tsa_lfsr
`default_nettype wire

//--- tsa_reader_model.sv
// reader-side model that issues decoded command frames to the tag
`timescale 1ns/1ps
`default_nettype none
module tsa_reader_model (
  input  wire logic                         mclk,
  output var  logic                         cmd_valid,
  output var  logic                         cmd_crc_ok,
  output var  logic [tsa_pkg::CMD_W-1:0]    cmd_code,
  output var  logic [tsa_pkg::HANDLE_W-1:0] cmd_param
);
  import tsa_pkg::*;

  initial begin
    cmd_valid  = 1'b0;
    cmd_crc_ok = 1'b0;
    cmd_code   = 4'hf;
    cmd_param  = 8'h00;
  end

  // one frame per call, after gap idle cycles; a single reader with a
  // single tag never has two tags picked at once
  // slot 0 comes from CMD_SLOT_ZERO, slots 1 to 15 from probes
  task automatic send(input logic [CMD_W-1:0]    code,
                      input logic [HANDLE_W-1:0] param,
                      input logic                crc,
                      input int                  gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    cmd_valid  <= 1'b1;
    cmd_crc_ok <= crc;
    cmd_code   <= code;
    cmd_param  <= param;
    @(posedge mclk);
    // released lines show junk, not the last frame
    cmd_valid  <= 1'b0;
    cmd_crc_ok <= ~crc;
    cmd_code   <= ~code;
    cmd_param  <= ~param;
  endtask : send
endmodule : tsa_reader_model
`default_nettype wire

//--- tsa_core_tb_top.sv
// self-checking testbench for the tag state and anticollision block
`timescale 1ns/1ps
`default_nettype none
module tsa_core_tb_top;
  import tsa_pkg::*;

  logic                mclk;
  logic                rst;
  logic                field_ok;
  logic                fixed_handle_en;
  logic [HANDLE_W-1:0] fixed_handle;
  logic                cmd_valid;
  logic                cmd_crc_ok;
  logic [CMD_W-1:0]    cmd_code;
  logic [HANDLE_W-1:0] cmd_param;
  tsa_state_t          tag_state;
  logic [HANDLE_W-1:0] tag_handle;
  logic                ans_valid;
  logic [HANDLE_W-1:0] ans_handle;
  logic                serve_valid;
  logic [CMD_W-1:0]    serve_cmd;
  int                  mismatches;
  int                  cmp_count;
  int                  cyc;

  tsa_core i_dut (
    .mclk(mclk), .rst(rst), .field_ok(field_ok),
    .fixed_handle_en(fixed_handle_en), .fixed_handle(fixed_handle),
    .cmd_valid(cmd_valid), .cmd_crc_ok(cmd_crc_ok), .cmd_code(cmd_code),
    .cmd_param(cmd_param), .tag_state(tag_state), .tag_handle(tag_handle),
    .ans_valid(ans_valid), .ans_handle(ans_handle),
    .serve_valid(serve_valid), .serve_cmd(serve_cmd)
  );

  tsa_reader_model i_reader (
    .mclk(mclk), .cmd_valid(cmd_valid), .cmd_crc_ok(cmd_crc_ok),
    .cmd_code(cmd_code), .cmd_param(cmd_param)
  );

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // a few hundred commands need well under this many cycles
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // outputs are looked at in the cycle after the taking edge
  task automatic cmd(input logic [3:0] code, input logic [7:0] param,
                     input logic crc = 1'b1);
    i_reader.send(code, param, crc, 0);
    #1;
  endtask : cmd

  task automatic outs(input logic a, input logic s, input tsa_state_t st);
    chk("ans_valid", {7'h0, ans_valid}, {7'h0, a});
    chk("serve_valid", {7'h0, serve_valid}, {7'h0, s});
    chk("tag_state", {5'h0, tag_state}, {5'h0, st});
  endtask : outs

  task automatic wait_state(input tsa_state_t st);
    for (int i = 0; i < 8 && tag_state !== st; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("state wait", {5'h0, tag_state}, {5'h0, st});
  endtask : wait_state

  task automatic t_off_and_ready();
    chk("handle at reset", tag_handle, HANDLE_RST);
    cmd(CMD_INV_OPEN, 8'h00);
    outs(1'b0, 1'b0, ST_OFF);
    @(posedge mclk);
    field_ok <= 1'b1;
    wait_state(ST_READY);
    for (int c = 1; c < 16; c++) begin
      cmd(c[3:0], tag_handle);
      outs(1'b0, 1'b0, ST_READY);
    end
    cmd(CMD_INV_OPEN, 8'h00);
    outs(1'b0, 1'b0, ST_INVENTORY);
  endtask : t_off_and_ready

  task automatic t_inventory();
    cmd(CMD_INV_OPEN, 8'h00);
    outs(1'b1, 1'b0, ST_INVENTORY);
    chk("open answer", ans_handle, tag_handle);
    cmd(CMD_INV_OPEN, 8'h00, 1'b0);
    outs(1'b0, 1'b0, ST_INVENTORY);
    for (int c = 9; c < 16; c++) begin
      cmd(c[3:0], tag_handle);
      outs(1'b0, 1'b0, ST_INVENTORY);
    end
  endtask : t_inventory

  task automatic t_slots();
    logic       hit;
    logic [3:0] n;
    hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++) begin
      cmd(CMD_SLOT_ZERO, 8'h00);
      hit = (tag_handle[3:0] == SLOT_ZERO);
      chk("zero call answer", {7'h0, ans_valid}, {7'h0, hit});
    end
    chk("zero slot drawn", {7'h0, hit}, 8'h01);
    chk("zero call handle", ans_handle, tag_handle);
    for (int i = 0; i < 64 && hit; i++) begin
      cmd(CMD_SLOT_ZERO, 8'h00);
      hit = (tag_handle[3:0] == SLOT_ZERO);
    end
    n = tag_handle[3:0];
    for (int s = 1; s < 16; s++) begin
      cmd(CMD_SLOT_PROBE, {4'h0, s[3:0]});
      outs(s[3:0] == n, 1'b0, ST_INVENTORY);
      if (s[3:0] == n) chk("probe handle", ans_handle, tag_handle);
    end
    cmd(CMD_SLOT_PROBE, {4'h0, n});
    outs(1'b0, 1'b0, ST_INVENTORY);
  endtask : t_slots

  task automatic t_select();
    logic [7:0] h;
    h = tag_handle;
    cmd(CMD_PICK_TAG, h ^ 8'h01);
    outs(1'b0, 1'b0, ST_INVENTORY);
    cmd(CMD_PICK_TAG, h);
    outs(1'b0, 1'b0, ST_SELECTED);
    for (int c = 0; c < 3; c++) begin
      cmd(c[3:0], {4'h0, h[3:0]});
      outs(1'b0, 1'b0, ST_SELECTED);
    end
    for (int c = 4; c < 8; c++) begin
      cmd(c[3:0], h);
      outs(1'b0, 1'b1, ST_SELECTED);
      chk("serve_cmd", {4'h0, serve_cmd}, {4'h0, c[3:0]});
    end
    cmd(CMD_PICK_TAG, h ^ 8'h80);
    outs(1'b0, 1'b0, ST_DESELECTED);
    for (int c = 0; c < 16; c++) begin
      if (c != 3) begin
        cmd(c[3:0], h);
        outs(1'b0, 1'b0, ST_DESELECTED);
      end
    end
    cmd(CMD_PICK_TAG, h);
    outs(1'b0, 1'b0, ST_SELECTED);
    cmd(CMD_RETIRE, h);
    outs(1'b0, 1'b0, ST_DEACTIVATED);
    for (int c = 0; c < 16; c++) begin
      cmd(c[3:0], h);
      outs(1'b0, 1'b0, ST_DEACTIVATED);
    end
  endtask : t_select

  task automatic t_field_and_fixed();
    @(posedge mclk);
    field_ok <= 1'b0;
    wait_state(ST_OFF);
    cmd(CMD_INV_OPEN, 8'h00);
    outs(1'b0, 1'b0, ST_OFF);
    @(posedge mclk);
    fixed_handle_en <= 1'b1;
    fixed_handle    <= 8'h5a;
    field_ok        <= 1'b1;
    wait_state(ST_READY);
    chk("fixed handle", tag_handle, 8'h5a);
    cmd(CMD_INV_OPEN, 8'h00);
    cmd(CMD_INV_OPEN, 8'h00);
    chk("fixed open answer", ans_handle, 8'h5a);
    cmd(CMD_SLOT_ZERO, 8'h00);
    outs(1'b0, 1'b0, ST_INVENTORY);
    cmd(CMD_SLOT_PROBE, 8'h0a);
    outs(1'b1, 1'b0, ST_INVENTORY);
    chk("fixed probe answer", ans_handle, 8'h5a);
  endtask : t_field_and_fixed

  initial begin
    mismatches      = 0;
    cmp_count       = 0;
    cyc             = 0;
    rst             = 1'b1;
    field_ok        = 1'b0;
    fixed_handle_en = 1'b0;
    fixed_handle    = 8'h00;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_off_and_ready();
    t_inventory();
    t_slots();
    t_select();
    t_field_and_fixed();
    report_and_stop();
  end
endmodule : tsa_core_tb_top
`default_nettype wire
